// >>> hw/carr_pkg.sv
`default_nettype none
package carr_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [11:0] CARR_CTRL_OFS = 12'h000; // Cache control register
  localparam logic [11:0] CARR_STAT_OFS = 12'h004; // Engine status, read only
  localparam logic [7:0] CARR_CTRL_RST = 8'h00; // Control reset value
  localparam int CARR_WSEL_HI = 7; // Way select high bit
  localparam int CARR_WSEL_LO = 6; // Way select low bit
  localparam int CARR_PURGE_BIT = 4; // Purge all
  localparam int CARR_HALF_BIT = 3; // Half RAM mode
  localparam int CARR_DFB_BIT = 2; // Data fill block
  localparam int CARR_IFB_BIT = 1; // Instruction fill block
  localparam int CARR_CE_BIT = 0; // Cache enable
  localparam logic [7:0] CARR_CTRL_WMASK = 8'hCF; // Stored bits
  // ----------------------------------------
  // Address spaces, top three address bits
  // ----------------------------------------
  localparam logic [2:0] CARR_SP_CACHE = 3'h0; // Cacheable area
  localparam logic [2:0] CARR_SP_PURGE = 3'h2; // Associative purge
  localparam logic [2:0] CARR_SP_AARR = 3'h3; // Address array window
  localparam logic [2:0] CARR_SP_DARR = 3'h6; // Data array window
  // ----------------------------------------
  // Geometry and address array layout
  // ----------------------------------------
  localparam int CARR_TAG_W = 19; // Tag is address bits 28..10
  localparam int CARR_ENT_N = 64; // Entries
  localparam int CARR_WAY_N = 4; // Ways
  localparam int CARR_LINE_WORDS = 4; // Longwords per 16-byte line
  localparam logic [1:0] CARR_LAST_CNT = 2'h3; // Last fill beat
  localparam int CARR_AA_VALID = 2; // Valid bit position
  localparam logic [1:0] CARR_SZ_BYTE = 2'h0; // Access sizes
  localparam logic [1:0] CARR_SZ_WORD = 2'h1;
  localparam logic [1:0] CARR_SZ_LONG = 2'h2;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    CARR_S_IDLE = 2'h0,
    CARR_S_FILL = 2'h1,
    CARR_S_THRU = 2'h3,
    CARR_S_PURGE = 2'h2
  } carr_state_t;
  typedef struct packed {
    logic [31:0] addr; // Byte address
    logic [31:0] wdata; // Write data, big-endian lanes
    logic [1:0] size; // Byte, word, longword
    logic we; // Write
    logic instr; // Instruction fetch
  } carr_req_t;
  typedef struct packed {
    logic [31:0] addr; // Memory byte address
    logic [31:0] wdata; // Memory write data
    logic [1:0] size; // Memory access size
    logic we; // Memory write
  } carr_mem_t;
endpackage
`default_nettype wire

// >>> hw/carr_cache.sv
`default_nettype none
module carr_cache
  import carr_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic cpu_valid_in,
  input wire carr_pkg::carr_req_t cpu_req_in,
  output logic cpu_ready_out,
  output logic [31:0] cpu_rdata_out,
  output logic mem_req_out,
  output carr_pkg::carr_mem_t mem_cmd_out,
  input wire logic mem_ack_in,
  input wire logic [31:0] mem_rdata_in
);
  import carr_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] ctl; // Control register
    logic [CARR_ENT_N-1:0][CARR_WAY_N-1:0] valid; // Valid bits
    logic [CARR_ENT_N-1:0][CARR_WAY_N-1:0][CARR_TAG_W-1:0] tag; // Tags
    logic [CARR_ENT_N-1:0][5:0] lru; // Order bits
    logic [CARR_WAY_N-1:0][255:0][31:0] data; // Data arrays
    carr_state_t fsm; // Engine state
    logic [1:0] cnt; // Fill beat count
    logic [1:0] ptr; // Fill word pointer
    logic [1:0] vic; // Fill way
    carr_req_t req; // Latched request
    logic done; // Answer to CPU
    logic [31:0] rdata; // CPU read data
    logic mreq; // Memory request
    carr_mem_t mcmd; // Memory command
    logic [31:0] prd; // APB read data, captured in setup
  } carr_st_t;

  carr_st_t st_ff; // Registered state
  carr_st_t nxt_st; // Next state

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Order bits after an access to a way
  function automatic logic [5:0] lru_upd(input logic [5:0] l, input logic [1:0] w);
    logic [5:0] r;
    r = l;
    case (w)
      2'h0: r = {3'b000, l[2:0]};
      2'h1: r = {1'b1, l[4:3], 2'b00, l[0]};
      2'h2: r = {l[5], 1'b1, l[3], 1'b1, l[1], 1'b0};
      default: r = {l[5:4], 1'b1, l[2], 2'b11};
    endcase
    return r;
  endfunction

  // Victim way from order bits
  function automatic logic [1:0] victim(input logic [5:0] l, input logic half);
    logic [1:0] v;
    v = 2'h3;
    if (half) begin
      v = l[0] ? 2'h2 : 2'h3;
    end else if (l[5] && l[4] && l[3]) begin
      v = 2'h0;
    end else if (!l[5] && l[2] && l[1]) begin
      v = 2'h1;
    end else if (!l[4] && !l[2] && l[0]) begin
      v = 2'h2;
    end
    return v;
  endfunction

  // Per-way tag match, invalid ways never hit
  function automatic logic [3:0] hit_vec(input logic [3:0] vld,
                                         input logic [3:0][CARR_TAG_W-1:0] tg,
                                         input logic [CARR_TAG_W-1:0] t);
    logic [3:0] h;
    h = 4'h0;
    for (int w = 0; w < CARR_WAY_N; w++) begin
      h[w] = vld[w] && (tg[w] == t);
    end
    return h;
  endfunction

  // One-hot to way number
  function automatic logic [1:0] way_of(input logic [3:0] h);
    logic [1:0] w;
    w = 2'h0;
    for (int i = 0; i < CARR_WAY_N; i++) begin
      if (h[i]) begin
        w = 2'(i);
      end
    end
    return w;
  endfunction

  // Big-endian byte lanes written
  function automatic logic [3:0] lanes(input logic [1:0] sz, input logic [1:0] a);
    logic [3:0] b;
    b = 4'hF;
    if (sz == CARR_SZ_BYTE) begin
      b = 4'h8 >> a;
    end else if (sz == CARR_SZ_WORD) begin
      b = a[1] ? 4'h3 : 4'hC;
    end
    return b;
  endfunction

  // Merge write data into a longword
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] b);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (b[i]) begin
        r[i*8 +: 8] = n[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------
  // Decode of the CPU request
  // ----------------------------------------
  logic take; // Request taken this cycle
  logic [2:0] space; // Address space
  logic [5:0] ent; // Entry index
  logic [7:0] didx; // Data array word index
  logic [CARR_TAG_W-1:0] rtag; // Request tag
  logic [3:0] hitv; // Hit per way
  logic hit; // Any hit
  logic [1:0] hway; // Hit way
  logic cache_on; // Cacheable and enabled
  logic fill_blk; // Replacement blocked
  logic go_fill; // Cacheable read miss starts a line fill, unless blocked
  logic apb_wr; // APB write access phase
  logic [1:0] wsel; // Way select field
  logic [31:0] apb_rdv; // APB read value before the flop

  assign take = cpu_valid_in && (st_ff.fsm == CARR_S_IDLE) && !st_ff.done;
  assign space = cpu_req_in.addr[31:29];
  assign ent = cpu_req_in.addr[9:4];
  assign didx = cpu_req_in.addr[9:2];
  assign rtag = cpu_req_in.addr[28:10];
  assign hitv = hit_vec(st_ff.valid[ent], st_ff.tag[ent], rtag);
  assign hit = |hitv;
  assign hway = way_of(hitv);
  assign cache_on = (space == CARR_SP_CACHE) && st_ff.ctl[CARR_CE_BIT];
  assign fill_blk = cpu_req_in.instr ? st_ff.ctl[CARR_IFB_BIT] : st_ff.ctl[CARR_DFB_BIT];
  assign go_fill = take && cache_on && !cpu_req_in.we && !hit && !fill_blk;
  assign apb_wr = psel_in && penable_in && pwrite_in;
  assign wsel = st_ff.ctl[CARR_WSEL_HI:CARR_WSEL_LO];

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    if (take) begin
      nxt_st.req = cpu_req_in;
      if (space == CARR_SP_DARR) begin
        // Direct data array, also plain RAM, one cycle
        nxt_st.done = 1'b1;
        nxt_st.rdata = st_ff.data[cpu_req_in.addr[11:10]][didx];
        if (cpu_req_in.we) begin
          nxt_st.data[cpu_req_in.addr[11:10]][didx] =
            merge(st_ff.data[cpu_req_in.addr[11:10]][didx], cpu_req_in.wdata,
                  lanes(cpu_req_in.size, cpu_req_in.addr[1:0]));
        end
      end else if (space == CARR_SP_AARR) begin
        // Address array, way from way select
        nxt_st.done = 1'b1;
        nxt_st.rdata = {3'h0, st_ff.tag[ent][wsel], st_ff.lru[ent], 1'b0,
                        st_ff.valid[ent][wsel], 2'h0};
        if (cpu_req_in.we) begin
          nxt_st.tag[ent][wsel] = rtag;
          nxt_st.valid[ent][wsel] = cpu_req_in.addr[CARR_AA_VALID];
          nxt_st.lru[ent] = cpu_req_in.wdata[9:4];
        end
      end else if (space == CARR_SP_PURGE) begin
        // Compare next cycle, no memory cycle
        nxt_st.fsm = CARR_S_PURGE;
      end else if (go_fill) begin
        // Tag and valid set now, before the line arrives
        nxt_st.vic = victim(st_ff.lru[ent], st_ff.ctl[CARR_HALF_BIT]);
        nxt_st.tag[ent][nxt_st.vic] = rtag;
        nxt_st.valid[ent][nxt_st.vic] = 1'b1;
        nxt_st.lru[ent] = lru_upd(st_ff.lru[ent], nxt_st.vic);
        nxt_st.ptr = cpu_req_in.addr[3:2] + 2'h1;
        nxt_st.cnt = 2'h0;
        nxt_st.fsm = CARR_S_FILL;
        nxt_st.mreq = 1'b1;
        nxt_st.mcmd = '{addr: {cpu_req_in.addr[31:4], cpu_req_in.addr[3:2] + 2'h1, 2'h0},
                        wdata: 32'h0, size: CARR_SZ_LONG, we: 1'b0};
      end else if (cache_on && hit && !cpu_req_in.we) begin
        // Read hit answered next cycle
        nxt_st.done = 1'b1;
        nxt_st.rdata = st_ff.data[hway][didx];
        nxt_st.lru[ent] = lru_upd(st_ff.lru[ent], hway);
      end else begin
        // Write-through, cache-through or blocked miss
        if (cache_on && hit) begin
          nxt_st.data[hway][didx] = merge(st_ff.data[hway][didx], cpu_req_in.wdata,
                                          lanes(cpu_req_in.size, cpu_req_in.addr[1:0]));
          nxt_st.lru[ent] = lru_upd(st_ff.lru[ent], hway);
        end
        nxt_st.fsm = CARR_S_THRU;
        nxt_st.mreq = 1'b1;
        nxt_st.mcmd = '{addr: cpu_req_in.addr, wdata: cpu_req_in.wdata,
                        size: cpu_req_in.size, we: cpu_req_in.we};
      end
    end
    case (st_ff.fsm)
      CARR_S_PURGE: begin
        // Invalidate matching ways only, order bits kept
        nxt_st.valid[st_ff.req.addr[9:4]] = st_ff.valid[st_ff.req.addr[9:4]] &
          ~hit_vec(st_ff.valid[st_ff.req.addr[9:4]], st_ff.tag[st_ff.req.addr[9:4]],
                   st_ff.req.addr[28:10]);
        nxt_st.done = 1'b1;
        nxt_st.fsm = CARR_S_IDLE;
      end
      CARR_S_FILL: begin
        // Four beats, requested word last
        if (mem_ack_in) begin
          nxt_st.data[st_ff.vic][{st_ff.req.addr[9:4], st_ff.ptr}] = mem_rdata_in;
          nxt_st.ptr = st_ff.ptr + 2'h1;
          nxt_st.cnt = st_ff.cnt + 2'h1;
          nxt_st.mcmd.addr = {st_ff.req.addr[31:4], st_ff.ptr + 2'h1, 2'h0};
          if (st_ff.cnt == CARR_LAST_CNT) begin
            nxt_st.done = 1'b1;
            nxt_st.rdata = mem_rdata_in;
            nxt_st.mreq = 1'b0;
            nxt_st.fsm = CARR_S_IDLE;
          end
        end
      end
      CARR_S_THRU: begin
        // Single memory access
        if (mem_ack_in) begin
          nxt_st.done = 1'b1;
          nxt_st.rdata = st_ff.mcmd.we ? 32'h0 : mem_rdata_in;
          nxt_st.mreq = 1'b0;
          nxt_st.fsm = CARR_S_IDLE;
        end
      end
      default: begin
      end
    endcase
    // Control register write, purge all in one cycle
    if (apb_wr && (paddr_in == CARR_CTRL_OFS)) begin
      nxt_st.ctl = pwdata_in[7:0] & CARR_CTRL_WMASK;
      if (pwdata_in[CARR_PURGE_BIT]) begin
        nxt_st.valid = '0;
        nxt_st.lru = '0;
      end
    end
    // Read data taken in setup, so access still needs no wait state
    if (psel_in && !penable_in) begin
      nxt_st.prd = apb_rdv;
    end
  end

  // ----------------------------------------
  // State register, reset clears control
  // ----------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign cpu_ready_out = st_ff.done;
  assign cpu_rdata_out = st_ff.rdata;
  assign mem_req_out = st_ff.mreq;
  assign mem_cmd_out = st_ff.mcmd;
  assign pready_out = 1'b1;
  assign prdata_out = st_ff.prd;

  // APB read decode, purge bit never stored
  always_comb begin
    apb_rdv = 32'h0;
    pslverr_out = 1'b0;
    if (paddr_in == CARR_CTRL_OFS) begin
      apb_rdv = {24'h0, st_ff.ctl};
    end else if (paddr_in == CARR_STAT_OFS) begin
      apb_rdv = {24'h0, st_ff.done, st_ff.mreq, st_ff.fsm, st_ff.cnt, st_ff.ptr};
    end else begin
      pslverr_out = psel_in && penable_in;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  logic [5:0] lru_exp; // Order bits expected after a read hit
  assign lru_exp = lru_upd(st_ff.lru[ent], hway);

  fill_tag_a: assert property (go_fill |=> st_ff.fsm == CARR_S_FILL &&
    st_ff.valid[st_ff.req.addr[9:4]][st_ff.vic] &&
    st_ff.tag[st_ff.req.addr[9:4]][st_ff.vic] == st_ff.req.addr[28:10])
    else $error("fill did not set tag and valid at once");
  half_vic_a: assert property (go_fill && st_ff.ctl[CARR_HALF_BIT] |=> st_ff.vic[1])
    else $error("half mode replaced way 0 or 1");
  zero_vic_a: assert property (go_fill && st_ff.lru[ent] == 6'h0
    && !st_ff.ctl[CARR_HALF_BIT] |=> st_ff.vic == 2'h3)
    else $error("cleared entry did not pick way 3");
  hit_lru_a: assert property (take && cache_on && hit && !cpu_req_in.we
    |=> st_ff.lru[$past(ent)] == $past(lru_exp) && st_ff.done)
    else $error("read hit order bits wrong");
  purge_all_a: assert property (apb_wr && paddr_in == CARR_CTRL_OFS
    && pwdata_in[CARR_PURGE_BIT] |=> st_ff.valid == '0 && st_ff.lru == '0
    && !st_ff.ctl[CARR_PURGE_BIT])
    else $error("purge all incomplete");
  purge_two_a: assert property (take && space == CARR_SP_PURGE
    |=> st_ff.fsm == CARR_S_PURGE && !st_ff.mreq ##1 st_ff.done && !st_ff.mreq)
    else $error("associative purge timing wrong");
  purge_lru_a: assert property (st_ff.fsm == CARR_S_PURGE |=> $stable(st_ff.lru))
    else $error("associative purge changed order bits");
  darr_one_a: assert property (take && space == CARR_SP_DARR |=> st_ff.done
    && st_ff.fsm == CARR_S_IDLE && !st_ff.mreq)
    else $error("data array access not one cycle");
  fill_len_a: assert property (st_ff.fsm == CARR_S_FILL && mem_ack_in
    && st_ff.cnt == CARR_LAST_CNT |=> st_ff.done && st_ff.rdata == $past(mem_rdata_in))
    else $error("fill did not end after four beats");
  blk_thru_a: assert property (take && cache_on && !cpu_req_in.we && !hit
    && fill_blk |=> st_ff.fsm == CARR_S_THRU && $stable(st_ff.valid))
    else $error("blocked miss replaced a line");
  no_ghost_a: assert property ((hitv & ~st_ff.valid[ent]) == 4'h0)
    else $error("invalid way produced a hit");

  fill_c: cover property (st_ff.fsm == CARR_S_FILL ##[1:40] st_ff.done);
  purge_c: cover property (st_ff.fsm == CARR_S_PURGE && |st_ff.valid[st_ff.req.addr[9:4]]);
  half_c: cover property (go_fill && st_ff.ctl[CARR_HALF_BIT]);
endmodule
`default_nettype wire

// >>> tb/carr_mem_model.sv
`default_nettype none
module carr_mem_model
  import carr_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [1:0] lat_in,
  input wire logic mem_req_in,
  input wire carr_pkg::carr_mem_t mem_cmd_in,
  output logic mem_ack_out,
  output logic [31:0] mem_rdata_out,
  output logic [15:0] acks_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wait_ff; // Idle cycles spent on this beat
  logic [31:0] junk_ff; // Changing pattern outside beats
  // Answer each beat after lat_in idle cycles, prompt or slow
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wait_ff <= 2'h0;
      mem_ack_out <= 1'b0;
      acks_out <= 16'h0000;
      junk_ff <= 32'h0F0F0F0F;
    end else begin
      junk_ff <= ~junk_ff;
      if (mem_req_in && !mem_ack_out && wait_ff == lat_in) begin
        wait_ff <= 2'h0;
        mem_ack_out <= 1'b1;
        acks_out <= acks_out + 16'h0001;
      end else begin
        wait_ff <= (mem_req_in && !mem_ack_out) ? wait_ff + 2'h1 : 2'h0;
        mem_ack_out <= 1'b0;
      end
    end
  end
  // Word data follows the beat address; junk when no beat
  assign mem_rdata_out = mem_ack_out ?
      ({mem_cmd_in.addr[31:2], 2'h0} ^ 32'hA5C30000) : junk_ff;
endmodule
`default_nettype wire

// >>> tb/test_cache_replacement_and_array_access.sv
`default_nettype none
module test_cache_replacement_and_array_access;
  timeunit 1ns;
  timeprecision 1ps;
  import carr_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk_in = 1'b0; // Bench clock
  logic rst_n_in;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic cpu_valid;
  carr_req_t cpu_req;
  logic cpu_ready;
  logic [31:0] cpu_rdata;
  logic mem_req;
  carr_mem_t mem_cmd;
  logic mem_ack;
  logic [31:0] mem_rdata;
  logic [1:0] lat; // Memory latency per beat
  logic [15:0] acks; // Memory beats so far
  logic [15:0] a0; // Beats before an access
  logic [31:0] rd;
  logic er;
  int n;
  logic ifetch; // Next request is an instruction fetch
  int err_total;
  int samples_checked;
  localparam logic [31:0] AM = 32'h1FFFFFF4; // Tag, order, valid
  localparam logic [31:0] VM = 32'h000003F4; // Order, valid
  always #20 clk_in = ~clk_in;
  carr_cache carr_cache_i (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .cpu_valid_in(cpu_valid),
    .cpu_req_in(cpu_req), .cpu_ready_out(cpu_ready), .cpu_rdata_out(cpu_rdata),
    .mem_req_out(mem_req), .mem_cmd_out(mem_cmd), .mem_ack_in(mem_ack),
    .mem_rdata_in(mem_rdata));
  carr_mem_model carr_mem_model_i (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .lat_in(lat), .mem_req_in(mem_req),
    .mem_cmd_in(mem_cmd), .mem_ack_out(mem_ack), .mem_rdata_out(mem_rdata),
    .acks_out(acks));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] mword(input logic [31:0] a);
    return {a[31:2], 2'h0} ^ 32'hA5C30000;
  endfunction
  function automatic logic [31:0] aa(input logic [18:0] t, input logic [5:0] o, input logic v);
    return {3'h0, t, o, 1'b0, v, 2'h0};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // APB setup, access until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int k;
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk_in);
      if (pready === 1'b1) break;
    end
    if (k == 50) begin
      err_total++;
      close_out();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // CPU request held until ready; c counts edges from take
  task automatic cpu(input logic [31:0] a, input logic w, input logic [31:0] d,
                     input logic [1:0] sz, output logic [31:0] r, output int c);
    @(posedge clk_in);
    cpu_valid <= 1'b1;
    cpu_req <= '{addr: a, wdata: d, size: sz, we: w, instr: ifetch};
    for (c = 1; c < 60; c++) begin
      @(posedge clk_in);
      if (cpu_ready === 1'b1) break;
    end
    if (c == 60) begin
      err_total++;
      close_out();
    end
    r = cpu_rdata;
    cpu_valid <= 1'b0;
  endtask
  // Address array read of way w, entry e
  task automatic aa_chk(input logic [7:0] ctl, input logic [1:0] w, input logic [5:0] e,
                        input logic [31:0] m, input logic [31:0] x);
    apb(1'b1, CARR_CTRL_OFS, {24'h0, w, ctl[5:0]}, rd, er);
    cpu(32'h60000000 | {22'h0, e, 4'h0}, 1'b0, 32'h0, CARR_SZ_LONG, rd, n);
    check(rd & m, x);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    apb(1'b0, CARR_CTRL_OFS, 32'h0, rd, er);
    check(rd, 32'h00000000);
    apb(1'b1, CARR_CTRL_OFS, 32'h000000CF, rd, er);
    apb(1'b0, CARR_CTRL_OFS, 32'h0, rd, er);
    check(rd, 32'h000000CF);
    rst_n_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    apb(1'b0, CARR_CTRL_OFS, 32'h0, rd, er);
    check(rd, 32'h00000000);
    apb(1'b0, 12'h008, 32'h0, rd, er);
    check({31'h0, er}, 32'h00000001);
    $display("reset done");
  endtask
  task automatic t_data();
    cpu(32'hC0000401, 1'b1, 32'hABABABAB, CARR_SZ_BYTE, rd, n);
    check(32'(n), 32'h2);
    cpu(32'hC0000402, 1'b1, 32'hCDEFCDEF, CARR_SZ_WORD, rd, n);
    cpu(32'hC0000400, 1'b0, 32'h0, CARR_SZ_LONG, rd, n);
    check(rd, 32'h00ABCDEF);
    check(32'(n), 32'h2);
    cpu(32'hC0000C04, 1'b1, 32'h12345678, CARR_SZ_LONG, rd, n);
    cpu(32'hC0000004, 1'b0, 32'h0, CARR_SZ_LONG, rd, n);
    check(rd, 32'h00000000);
    cpu(32'hC0000C04, 1'b0, 32'h0, CARR_SZ_LONG, rd, n);
    check(rd, 32'h12345678);
    $display("data array done");
  endtask
  task automatic t_fill();
    logic [31:0] a;
    apb(1'b1, CARR_CTRL_OFS, 32'h00000001, rd, er);
    lat <= 2'h2;
    for (int t = 1; t <= 4; t++) begin
      a = (32'(t) << 10) | 32'h00000058;
      a0 = acks;
      cpu(a, 1'b0, 32'h0, CARR_SZ_LONG, rd, n);
      check(rd, mword(a));
      check(32'(acks - a0), 32'h4);
    end
    for (int w = 0; w < 4; w++) begin
      aa_chk(8'h01, 2'(w), 6'h05, AM, aa(19'(4 - w), 6'h00, 1'b1));
    end
    $display("fill done");
  endtask
  task automatic t_hit();
    lat <= 2'h0;
    a0 = acks;
    cpu(32'h0000085C, 1'b0, 32'h0, CARR_SZ_LONG, rd, n);
    check(rd, mword(32'h0000085C));
    check(32'(n), 32'h2);
    check(32'(acks - a0), 32'h0);
    aa_chk(8'h01, 2'h2, 6'h05, AM, aa(19'h2, 6'h14, 1'b1));
    cpu(32'h00001050, 1'b1, 32'h55AA55AA, CARR_SZ_LONG, rd, n);
    aa_chk(8'h01, 2'h0, 6'h05, AM, aa(19'h4, 6'h04, 1'b1));
    $display("hit done");
  endtask
  task automatic t_apurge();
    a0 = acks;
    cpu(32'h40000850, 1'b1, 32'h0, CARR_SZ_LONG, rd, n);
    check(32'(n), 32'h3);
    check(32'(acks - a0), 32'h0);
    aa_chk(8'h01, 2'h2, 6'h05, VM, 32'h00000040);
    aa_chk(8'h01, 2'h1, 6'h05, AM, aa(19'h3, 6'h04, 1'b1));
    a0 = acks;
    cpu(32'h00000850, 1'b0, 32'h0, CARR_SZ_LONG, rd, n);
    check(32'(acks - a0), 32'h4);
    $display("line purge done");
  endtask
  task automatic t_purge();
    apb(1'b1, CARR_CTRL_OFS, 32'h00000011, rd, er);
    apb(1'b0, CARR_CTRL_OFS, 32'h0, rd, er);
    check(rd, 32'h00000001);
    for (int w = 0; w < 4; w++) begin
      aa_chk(8'h01, 2'(w), 6'h05, VM, 32'h0);
    end
    $display("purge done");
  endtask
  task automatic t_block();
    apb(1'b1, CARR_CTRL_OFS, 32'h00000005, rd, er);
    a0 = acks;
    cpu(32'h00001C60, 1'b0, 32'h0, CARR_SZ_LONG, rd, n);
    check(rd, mword(32'h00001C60));
    check(32'(acks - a0), 32'h1);
    check(mem_cmd.addr, 32'h00001C60);
    aa_chk(8'h05, 2'h3, 6'h06, VM, 32'h0);
    apb(1'b1, CARR_CTRL_OFS, 32'h00000003, rd, er);
    ifetch = 1'b1;
    a0 = acks;
    cpu(32'h00002060, 1'b0, 32'h0, CARR_SZ_LONG, rd, n);
    check(rd, mword(32'h00002060));
    check(32'(acks - a0), 32'h1);
    ifetch = 1'b0;
    a0 = acks;
    cpu(32'h00002060, 1'b0, 32'h0, CARR_SZ_LONG, rd, n);
    check(32'(acks - a0), 32'h4);
    $display("fill block done");
  endtask
  task automatic t_half();
    apb(1'b1, CARR_CTRL_OFS, 32'h00000010, rd, er);
    apb(1'b1, CARR_CTRL_OFS, 32'h00000009, rd, er);
    lat <= 2'h1;
    for (int t = 1; t <= 3; t++) begin
      cpu((32'(t) << 10) | 32'h00000080, 1'b0, 32'h0, CARR_SZ_LONG, rd, n);
    end
    aa_chk(8'h09, 2'h0, 6'h08, 32'h4, 32'h0);
    aa_chk(8'h09, 2'h1, 6'h08, 32'h4, 32'h0);
    aa_chk(8'h09, 2'h2, 6'h08, 32'h1FFFFC04, aa(19'h2, 6'h0, 1'b1));
    aa_chk(8'h09, 2'h3, 6'h08, 32'h1FFFFC04, aa(19'h3, 6'h0, 1'b1));
    $display("half mode done");
  endtask
  task automatic t_aaw();
    apb(1'b1, CARR_CTRL_OFS, 32'h00000001, rd, er);
    cpu(32'h60002484, 1'b1, 32'h0, CARR_SZ_LONG, rd, n);
    aa_chk(8'h01, 2'h0, 6'h08, AM, aa(19'h9, 6'h0, 1'b1));
    a0 = acks;
    cpu(32'h00002480, 1'b0, 32'h0, CARR_SZ_LONG, rd, n);
    check(32'(acks - a0), 32'h0);
    check(32'(n), 32'h2);
    $display("array write done");
  endtask
  // Reset, then the scenario list
  initial begin
    rst_n_in = 1'b0;
    ifetch = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    cpu_valid = 1'b0;
    cpu_req = '0;
    lat = 2'h0;
    err_total = 0;
    samples_checked = 0;
    repeat (10) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_reset();
    t_data();
    t_fill();
    t_hit();
    t_apurge();
    t_purge();
    t_block();
    t_half();
    t_aaw();
    close_out();
  end
endmodule
`default_nettype wire
